// ==== rtl/pii_top.sv ====
// Priority interrupt intake: ranks request sources for the processor core
`timescale 1ns/1ps
`include "pii_map.svh"

// Operation
// - Encoded pins decode inversely: 0000 is level 15, 1111 is no request.
// - Encoded request level comes straight from the pin pattern.
// - Pattern must match on two consecutive samples before it is accepted.
// - In standby the filter samples on the 32.768 kHz RTC clock.
// - Without the RTC oscillator, encoded requests are ignored in standby.
// - Acceptance never changes the processor's four-bit mask field.
// - Port inputs are level sensed, one priority per group of eight.
// - Each peripheral module has its own 0-15 priority field.
// - Accepted source is reported through the event code registers.
// - Every source but the encoded pins has its own distinct secondary event code.
// - Reset clears every programmable priority to zero.
// - Ties on level go to the fixed default ranking order.
// - Timer and RTC wake standby only above the mask with RTC running.
// - Priority zero masks a source.
// - Grouped sources: primary code by level, secondary code by source.
module pii_top
  import pii_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request sources
  input wire logic [3:0] encoded_level_request_pins_n_i,
  input wire logic [15:0] port_request_inputs_i,
  input wire logic [10:0] periph_req_i,
  // Priority settings, loaded together
  input wire logic prio_load_i,
  input wire logic [15:0] priority_setting_a_i,
  input wire logic [15:0] priority_setting_b_i,
  input wire logic [15:0] priority_setting_d_i,
  input wire logic [15:0] priority_setting_e_i,
  // Processor side
  input wire logic [3:0] cpu_interrupt_mask_field_i,
  input wire logic cpu_ack_i,
  input wire logic standby_i,
  // RTC oscillator
  input wire logic rtc_clk_i,
  input wire logic rtc_osc_on_i,
  // Outputs
  output logic irq_req_o,
  output logic [3:0] irq_level_o,
  output logic [11:0] primary_event_code_reg_o,
  output logic [11:0] secondary_event_code_reg_o,
  output logic wake_o
);

  // --------------------------------------------------------------------------
  // Code and priority lookup
  // --------------------------------------------------------------------------
  function automatic logic [11:0] lvl_code(input logic [3:0] lvl);
    lvl_code = `PII_CODE_LVL_BASE + {3'h0, ~lvl, 5'h00};
  endfunction

  function automatic logic [11:0] src_code(input pii_src_t s,
                                           input logic [3:0] lvl);
    case (s)
      PII_SRC_PORT_LO: src_code = `PII_CODE_PORT_LO;
      PII_SRC_PORT_HI: src_code = `PII_CODE_PORT_HI;
      PII_SRC_DMAC: src_code = `PII_CODE_DMAC;
      PII_SRC_IRDA: src_code = `PII_CODE_IRDA;
      PII_SRC_SCIF: src_code = `PII_CODE_SCIF;
      PII_SRC_ADC: src_code = `PII_CODE_ADC;
      PII_SRC_TMU0: src_code = `PII_CODE_TMU0;
      PII_SRC_TMU1: src_code = `PII_CODE_TMU1;
      PII_SRC_TMU2: src_code = `PII_CODE_TMU2;
      PII_SRC_RTC: src_code = `PII_CODE_RTC;
      PII_SRC_SCI: src_code = `PII_CODE_SCI;
      PII_SRC_WDT: src_code = `PII_CODE_WDT;
      PII_SRC_REF: src_code = `PII_CODE_REF;
      default: src_code = lvl_code(lvl);
    endcase
  endfunction

  pii_state_t st_q, st_d;
  logic [3:0] enc_acc;
  logic [3:0] enc_lvl;
  logic rtc_edge;
  logic tick;
  logic [3:0] lvl [14];
  logic [13:0] pend;
  logic [3:0] best_lvl;
  pii_src_t best_src;

  // --------------------------------------------------------------------------
  // Encoded request filter
  // --------------------------------------------------------------------------
  // RTC clock is only sampled; it is far slower than the system clock
  assign rtc_edge = st_q.rtc_s2 && !st_q.rtc_prev;
  // Standby samples on RTC edges, and not at all with the oscillator off
  assign tick = standby_i ? (rtc_edge && st_q.rtcon_s2) : 1'b1;

  pii_filter u_filter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .sample_i(tick),
    .pins_i(st_q.enc_s2),
    .accepted_o(enc_acc)
  );

  // Level is the inverted pattern held in the filter's accepted register
  assign enc_lvl = (standby_i && !st_q.rtcon_s2) ? 4'h0 : ~enc_acc;

  // --------------------------------------------------------------------------
  // Per-source levels
  // --------------------------------------------------------------------------
  always_comb begin
    lvl[PII_SRC_ENC] = enc_lvl;
    // One level per group of eight port inputs
    lvl[PII_SRC_PORT_LO] = st_q.prio_d[`PII_LSB_PORT_LO +: 4];
    lvl[PII_SRC_PORT_HI] = st_q.prio_d[`PII_LSB_PORT_HI +: 4];
    // Own field per peripheral module
    lvl[PII_SRC_DMAC] = st_q.prio_e[`PII_LSB_DMAC +: 4];
    lvl[PII_SRC_IRDA] = st_q.prio_e[`PII_LSB_IRDA +: 4];
    lvl[PII_SRC_SCIF] = st_q.prio_e[`PII_LSB_SCIF +: 4];
    lvl[PII_SRC_ADC] = st_q.prio_e[`PII_LSB_ADC +: 4];
    lvl[PII_SRC_TMU0] = st_q.prio_a[`PII_LSB_TMU0 +: 4];
    lvl[PII_SRC_TMU1] = st_q.prio_a[`PII_LSB_TMU1 +: 4];
    lvl[PII_SRC_TMU2] = st_q.prio_a[`PII_LSB_TMU2 +: 4];
    lvl[PII_SRC_RTC] = st_q.prio_a[`PII_LSB_RTC +: 4];
    lvl[PII_SRC_SCI] = st_q.prio_b[`PII_LSB_SCI +: 4];
    lvl[PII_SRC_WDT] = st_q.prio_b[`PII_LSB_WDT +: 4];
    lvl[PII_SRC_REF] = st_q.prio_b[`PII_LSB_REF +: 4];
  end

  // Port inputs are levels, no latching
  assign pend = {periph_req_i,
                 |st_q.port_s2[15:8],
                 |st_q.port_s2[7:0],
                 1'b1};

  // --------------------------------------------------------------------------
  // Ranking
  // --------------------------------------------------------------------------
  always_comb begin
    best_lvl = 4'h0;
    best_src = PII_SRC_ENC;
    // Strict compare keeps the earliest source on a tie
    for (int i = 0; i < 14; i++) begin
      if (pend[i] && lvl[i] > best_lvl) begin
        best_lvl = lvl[i];
        best_src = pii_src_t'(i[3:0]);
      end
    end
  end

  // --------------------------------------------------------------------------
  // State update
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.enc_s1 = encoded_level_request_pins_n_i;
    st_d.enc_s2 = st_q.enc_s1;
    st_d.port_s1 = port_request_inputs_i;
    st_d.port_s2 = st_q.port_s1;
    st_d.rtc_s1 = rtc_clk_i;
    st_d.rtc_s2 = st_q.rtc_s1;
    st_d.rtc_prev = st_q.rtc_s2;
    st_d.rtcon_s1 = rtc_osc_on_i;
    st_d.rtcon_s2 = st_q.rtcon_s1;
    if (prio_load_i) begin
      st_d.prio_a = priority_setting_a_i;
      st_d.prio_b = priority_setting_b_i;
      st_d.prio_d = priority_setting_d_i;
      st_d.prio_e = priority_setting_e_i;
    end
    // Mask is only read here, never driven
    st_d.req = best_lvl > cpu_interrupt_mask_field_i;
    st_d.level = best_lvl;
    st_d.src = best_src;
    // Codes of what the core was shown when it accepted
    if (cpu_ack_i && st_q.req) begin
      st_d.sec = src_code(st_q.src, st_q.level);
      st_d.prim = (st_q.src < PII_SRC_TMU0) ?
                  lvl_code(st_q.level) : st_d.sec;
    end
    // Only encoded, timer and RTC sources may wake
    st_d.wake = standby_i && st_q.rtcon_s2 && st_d.req &&
                (best_src == PII_SRC_ENC ||
                 (best_src >= PII_SRC_TMU0 && best_src <= PII_SRC_RTC));
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      st_q.enc_s1 <= `PII_ENC_IDLE;
      st_q.enc_s2 <= `PII_ENC_IDLE;
      st_q.prio_a <= `PII_PRIO_RST;
      st_q.prio_b <= `PII_PRIO_RST;
      st_q.prio_d <= `PII_PRIO_RST;
      st_q.prio_e <= `PII_PRIO_RST;
      st_q.prim <= `PII_CODE_RST;
      st_q.sec <= `PII_CODE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq_req_o = st_q.req;
  assign irq_level_o = st_q.level;
  assign primary_event_code_reg_o = st_q.prim;
  assign secondary_event_code_reg_o = st_q.sec;
  assign wake_o = st_q.wake;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  mask_gate_a: assert property (
    irq_req_o |-> irq_level_o > $past(cpu_interrupt_mask_field_i))
    else $error("request level not above mask");

  zero_masked_a: assert property (
    irq_req_o |-> irq_level_o != 4'h0)
    else $error("level zero forwarded");

  enc_decode_a: assert property (
    (!standby_i && st_q.enc_s2 == 4'h0) [*2] |=> enc_acc == 4'h0 &&
    enc_lvl == 4'hf)
    else $error("pattern 0000 not level 15");

  glitch_reject_a: assert property (
    tick && st_q.enc_s2 != u_filter.st_q.last |=> enc_acc == $past(enc_acc))
    else $error("single sample accepted");

  rtc_off_a: assert property (
    standby_i && !st_q.rtcon_s2 |=> !(irq_req_o && st_q.src == PII_SRC_ENC))
    else $error("encoded request seen with RTC off");

  port_group_a: assert property (
    irq_req_o && st_q.src == PII_SRC_PORT_LO |->
    irq_level_o == $past(st_q.prio_d[`PII_LSB_PORT_LO +: 4]))
    else $error("port group level wrong");

  grp_code_a: assert property (
    cpu_ack_i && irq_req_o && st_q.src < PII_SRC_TMU0 |=>
    primary_event_code_reg_o == lvl_code($past(irq_level_o)))
    else $error("primary code not by level");

  code_hold_a: assert property (
    !(cpu_ack_i && irq_req_o) |=> $stable(secondary_event_code_reg_o))
    else $error("event code moved without acceptance");

  wake_gate_a: assert property (
    wake_o |-> $past(standby_i) && $past(st_q.rtcon_s2) && irq_req_o)
    else $error("wake without standby or RTC");

  enc_req_c: cover property (irq_req_o && st_q.src == PII_SRC_ENC);
  ack_c: cover property (cpu_ack_i && irq_req_o && st_q.src == PII_SRC_TMU0);
  wake_c: cover property (wake_o);

endmodule

// ==== rtl/pii_map.svh ====
// Constants for the priority interrupt intake: codes, field positions, resets
`ifndef PII_MAP_SVH
`define PII_MAP_SVH

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PII_PRIO_RST 16'h0000
`define PII_ENC_IDLE 4'hf
`define PII_CODE_RST 12'h000

// ----------------------------------------------------------------------------
// Event codes
// ----------------------------------------------------------------------------
`define PII_CODE_LVL_BASE 12'h200
`define PII_CODE_PORT_LO 12'h700
`define PII_CODE_PORT_HI 12'h720
`define PII_CODE_DMAC 12'h800
`define PII_CODE_IRDA 12'h880
`define PII_CODE_SCIF 12'h900
`define PII_CODE_ADC 12'h980
`define PII_CODE_TMU0 12'h400
`define PII_CODE_TMU1 12'h420
`define PII_CODE_TMU2 12'h440
`define PII_CODE_RTC 12'h480
`define PII_CODE_SCI 12'h4e0
`define PII_CODE_WDT 12'h560
`define PII_CODE_REF 12'h580

// ----------------------------------------------------------------------------
// Priority field positions (low bit of each 4-bit field)
// ----------------------------------------------------------------------------
`define PII_LSB_TMU0 12
`define PII_LSB_TMU1 8
`define PII_LSB_TMU2 4
`define PII_LSB_RTC 0
`define PII_LSB_WDT 12
`define PII_LSB_REF 8
`define PII_LSB_SCI 4
`define PII_LSB_PORT_LO 12
`define PII_LSB_PORT_HI 8
`define PII_LSB_DMAC 12
`define PII_LSB_IRDA 8
`define PII_LSB_SCIF 4
`define PII_LSB_ADC 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PII_STABLE_SAMPLES 2

`endif

// ==== rtl/pii_pkg.sv ====
// Types for the priority interrupt intake
package pii_pkg;

  // Sources in default ranking order, first is served first on a tie
  typedef enum logic [3:0] {
    PII_SRC_ENC,
    PII_SRC_PORT_LO,
    PII_SRC_PORT_HI,
    PII_SRC_DMAC,
    PII_SRC_IRDA,
    PII_SRC_SCIF,
    PII_SRC_ADC,
    PII_SRC_TMU0,
    PII_SRC_TMU1,
    PII_SRC_TMU2,
    PII_SRC_RTC,
    PII_SRC_SCI,
    PII_SRC_WDT,
    PII_SRC_REF
  } pii_src_t;

  typedef struct packed {
    logic [3:0] last;
    logic [3:0] accepted;
  } pii_filt_t;

  typedef struct packed {
    logic [3:0] enc_s1;
    logic [3:0] enc_s2;
    logic [15:0] port_s1;
    logic [15:0] port_s2;
    logic rtc_s1;
    logic rtc_s2;
    logic rtc_prev;
    logic rtcon_s1;
    logic rtcon_s2;
    logic [15:0] prio_a;
    logic [15:0] prio_b;
    logic [15:0] prio_d;
    logic [15:0] prio_e;
    logic req;
    logic [3:0] level;
    pii_src_t src;
    logic [11:0] prim;
    logic [11:0] sec;
    logic wake;
  } pii_state_t;

endpackage

// ==== rtl/pii_filter.sv ====
// Two-sample noise filter for the encoded level request pins
`timescale 1ns/1ps
`include "pii_map.svh"

module pii_filter
  import pii_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Sampling
  input wire logic sample_i,
  input wire logic [3:0] pins_i,
  // Accepted pattern
  output logic [3:0] accepted_o
);

  pii_filt_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (sample_i) begin
      st_d.last = pins_i;
      // Same pattern on two consecutive samples before it counts
      if (pins_i == st_q.last) begin
        st_d.accepted = pins_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q.last <= `PII_ENC_IDLE;
      st_q.accepted <= `PII_ENC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign accepted_o = st_q.accepted;

endmodule

// ==== verif/pii_far_end.sv ====
// Far end model: request encoding logic and core acknowledge
`timescale 1ns/1ps

module pii_far_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Commands
  input wire logic [3:0] lvl_i,
  input wire logic [15:0] port_i,
  input wire logic free_i,
  input wire logic ack_en_i,
  input wire logic slow_i,
  // Device side
  input wire logic irq_req_i,
  output logic [3:0] pins_n_o,
  output logic [15:0] ports_o,
  output logic cpu_ack_o
);
  logic [3:0] lvl_q = 4'h0;
  logic [15:0] port_q = 16'h0000;
  logic done_q = 1'b0;
  logic [1:0] wait_q = 2'h0;
  logic ack_q = 1'b0;
  assign cpu_ack_o = ack_q;
  assign pins_n_o = ~lvl_q;
  assign ports_o = port_q;
  always @(negedge clk_i) begin
    if (!nrst_i) begin
      lvl_q <= 4'h0;
      port_q <= 16'h0000;
      done_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      // Lowering waits for the ack, free_i breaks that on purpose
      if (free_i || done_q || lvl_i > lvl_q) lvl_q <= lvl_i;
      port_q <= (free_i || done_q) ? port_i : (port_q | port_i);
      ack_q <= 1'b0;
      if (!ack_en_i) begin
        done_q <= 1'b0;
        wait_q <= slow_i ? 2'h3 : 2'h0;
      end else if (!done_q && irq_req_i) begin
        if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
        else begin
          ack_q <= 1'b1;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verif/priority_interrupt_intake_test.sv ====
// Self-checking bench for the priority interrupt intake
`timescale 1ns/1ps
`include "pii_map.svh"

module priority_interrupt_intake_test
  import pii_pkg::*;
;
  localparam logic [11:0] CODES [13] = '{`PII_CODE_PORT_LO,
    `PII_CODE_PORT_HI, `PII_CODE_DMAC, `PII_CODE_IRDA, `PII_CODE_SCIF,
    `PII_CODE_ADC, `PII_CODE_TMU0, `PII_CODE_TMU1, `PII_CODE_TMU2,
    `PII_CODE_RTC, `PII_CODE_SCI, `PII_CODE_WDT, `PII_CODE_REF};
  localparam int REGI [13] = '{2, 2, 3, 3, 3, 3, 0, 0, 0, 0, 1, 1, 1};
  localparam int LSB [13] = '{`PII_LSB_PORT_LO, `PII_LSB_PORT_HI,
    `PII_LSB_DMAC, `PII_LSB_IRDA, `PII_LSB_SCIF, `PII_LSB_ADC,
    `PII_LSB_TMU0, `PII_LSB_TMU1, `PII_LSB_TMU2, `PII_LSB_RTC,
    `PII_LSB_SCI, `PII_LSB_WDT, `PII_LSB_REF};
  logic clk_i = 0, nrst_i = 0, rtc = 0, osc = 0, stby = 0, load = 0;
  logic free = 0, ack_en = 0, slow = 0, t1 = 0, t2 = 0;
  logic [3:0] lvl = 0, mask = 0, r;
  logic [15:0] port = 0, pa = 0, pb = 0, pd = 0, pe = 0;
  logic [15:0] w [4];
  logic [10:0] periph = 0;
  logic [3:0] pins_n, irq_level;
  logic [15:0] ports;
  logic cpu_ack, irq_req, wake;
  logic [11:0] prim, sec;
  logic [23:0] exp_c;
  logic [23:0] q [$];
  logic [31:0] seed = 32'hc989;
  int err_count = 0, n_tests = 0;

  always #50 clk_i = ~clk_i;
  // Free-running RTC, only its enable is switched
  always #15259 rtc = ~rtc;

  pii_far_end far (.clk_i(clk_i), .nrst_i(nrst_i), .lvl_i(lvl),
    .port_i(port), .free_i(free), .ack_en_i(ack_en), .slow_i(slow),
    .irq_req_i(irq_req), .pins_n_o(pins_n), .ports_o(ports),
    .cpu_ack_o(cpu_ack));
  pii_top dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .encoded_level_request_pins_n_i(pins_n), .port_request_inputs_i(ports),
    .periph_req_i(periph), .prio_load_i(load), .priority_setting_a_i(pa),
    .priority_setting_b_i(pb), .priority_setting_d_i(pd),
    .priority_setting_e_i(pe), .cpu_interrupt_mask_field_i(mask),
    .cpu_ack_i(cpu_ack), .standby_i(stby), .rtc_clk_i(rtc),
    .rtc_osc_on_i(osc), .irq_req_o(irq_req), .irq_level_o(irq_level),
    .primary_event_code_reg_o(prim), .secondary_event_code_reg_o(sec),
    .wake_o(wake));

  // --------
  // Helpers
  // --------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wt(input bit wk, input int n);
    for (int i = 0; i < n && (wk ? wake : irq_req) !== 1'b1; i++) cyc(1);
  endtask
  task automatic set_prio(input logic [15:0] a, b, d, e);
    pa <= a;
    pb <= b;
    pd <= d;
    pe <= e;
    load <= 1;
    cyc(1);
    load <= 0;
    cyc(1);
  endtask
  // Ack, then change the far end while lowering is allowed
  task automatic ack(input logic [11:0] p, s, input logic [3:0] nl,
                     input logic [15:0] np);
    q.push_back({p, s});
    ack_en <= 1;
    for (int i = 0; i < 20 && cpu_ack !== 1'b1; i++) cyc(1);
    cyc(1);
    lvl <= nl;
    port <= np;
    cyc(2);
    ack_en <= 0;
    cyc(8);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // --------
  // Code monitor
  // --------
  always @(posedge clk_i) begin
    t1 <= cpu_ack && irq_req;
    t2 <= t1;
  end
  always @(negedge clk_i) begin
    if (t2 && q.size() > 0) begin
      exp_c = q.pop_front();
      check(prim, exp_c[23:12]);
      check(sec, exp_c[11:0]);
    end
  end

  initial begin
    #(20000 * 100);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test;
  end

  // --------
  // Scenarios
  // --------
  initial begin
    cyc(10);
    nrst_i <= 1;
    periph <= 11'h7ff;
    port <= 16'hffff;
    cyc(8);
    check(irq_req, 0);
    check(prim, 12'h000);
    for (int p = 0; p < 15; p++) begin
      lvl <= 4'(15 - p);
      wt(0, 20);
      cyc(2);
      check(irq_req, 1);
      check(irq_level, 12'(15 - p));
      ack(12'h200 + 12'(p * 32), 12'h200 + 12'(p * 32), 4'(14 - p),
          16'hffff);
    end
    check(irq_req, 0);
    free <= 1;
    lvl <= 4'hf;
    cyc(1);
    lvl <= 4'h0;
    cyc(8);
    check(irq_req, 0);
    lvl <= 4'h5;
    mask <= 4'h5;
    cyc(8);
    check(irq_req, 0);
    mask <= 4'h4;
    cyc(3);
    check(irq_level, 12'h5);
    check(irq_req, 1);
    lvl <= 4'h0;
    mask <= 4'h0;
    cyc(8);
    free <= 0;
    for (int i = 0; i < 13; i++) begin
      seed = xs(seed);
      r = (seed[3:0] == 4'h0) ? 4'h1 : seed[3:0];
      slow <= seed[4];
      w = '{default: 16'h0000};
      w[REGI[i]][LSB[i] +: 4] = r;
      set_prio(w[0], w[1], w[2], w[3]);
      wt(0, 10);
      check(irq_level, 12'(r));
      ack(i < 6 ? 12'h200 + 12'((15 - r) * 32) : CODES[i], CODES[i],
          4'h0, 16'hffff);
    end
    set_prio(16'h7777, 16'h7777, 16'h7700, 16'h7777);
    lvl <= 4'h7;
    cyc(8);
    check(irq_level, 12'h7);
    ack(12'h300, 12'h300, 4'h0, 16'hffff);
    ack(12'h300, 12'h700, 4'h0, 16'h0000);
    ack(12'h300, 12'h800, 4'h0, 16'h0000);
    periph <= 11'h000;
    free <= 1;
    stby <= 1;
    lvl <= 4'h9;
    cyc(1000);
    check(wake, 0);
    check(irq_req, 0);
    osc <= 1;
    wt(1, 2000);
    check(wake, 1);
    lvl <= 4'h0;
    cyc(1000);
    set_prio(16'h5000, 16'h0050, 16'h0000, 16'h0000);
    mask <= 4'h3;
    periph <= 11'h010;
    wt(1, 20);
    check(wake, 1);
    mask <= 4'h5;
    cyc(4);
    check(wake, 0);
    mask <= 4'h0;
    periph <= 11'h100;
    cyc(5);
    check(irq_req, 1);
    check(wake, 0);
    // Every noted acceptance must have shown up at the code registers
    check(12'(q.size()), 12'h000);
    end_of_test;
  end
endmodule
